// ---- src/crs_regset.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "crs_regset_defs.svh"
module crs_regset #(
	parameter int                    XLEN       = `CRS_XLEN,
	parameter int                    VEC_W      = 8,
	parameter logic [`CRS_XLEN-1:0] RESET_PC   = 32'h0000_0000
) (
	// Clock and reset
	input  wire logic                     ref_clk_i,
	input  wire logic                     rst_n_i,
	// General-purpose register ports
	input  wire logic [`CRS_GPR_IDX_W-1:0] rd_a_idx_i,
	input  wire logic [`CRS_GPR_IDX_W-1:0] rd_b_idx_i,
	output logic      [XLEN-1:0]          rd_a_data_o,
	output logic      [XLEN-1:0]          rd_b_data_o,
	input  wire logic                     gpr_wr_i,
	input  wire logic [`CRS_GPR_IDX_W-1:0] gpr_wr_idx_i,
	input  wire logic [XLEN-1:0]          gpr_wr_data_i,
	// Control register move port
	input  wire logic [`CRS_CR_IDX_W-1:0]  cr_idx_i,
	input  wire logic                     cr_wr_i,
	input  wire logic [XLEN-1:0]          cr_wr_data_i,
	output logic      [XLEN-1:0]          cr_rd_data_o,
	// Execution results
	input  wire logic                     pc_load_i,
	input  wire logic [XLEN-1:0]          pc_next_i,
	input  wire logic                     psw_load_i,
	input  wire logic [XLEN-1:0]          psw_next_i,
	// Interrupt and exception path
	input  wire logic                     fast_irq_ack_i,
	input  wire logic                     fast_irq_ret_i,
	input  wire logic [VEC_W-1:0]         exc_vec_num_i,
	input  wire logic [VEC_W-1:0]         irq_vec_num_i,
	output logic      [XLEN-1:0]          exc_vec_addr_o,
	output logic      [XLEN-1:0]          irq_vec_addr_o,
	// Visible state
	output logic      [XLEN-1:0]          program_counter_o,
	output logic      [XLEN-1:0]          processor_status_word_o,
	output logic                          stack_sel_user_o,
	output logic      [XLEN-1:0]          stack_pointer_o
);
	crs_gpr_if gpr ();

	logic rst_meta_r;
	logic rst_sync_r;

	// Release is synchronised so no register leaves reset on a partial edge.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	crs_regset_pkg::crs_word_t program_counter_r;
	crs_regset_pkg::crs_word_t program_counter_nxt;
	crs_regset_pkg::crs_word_t processor_status_word_r;
	crs_regset_pkg::crs_word_t processor_status_word_nxt;
	crs_regset_pkg::crs_word_t saved_program_counter_r;
	crs_regset_pkg::crs_word_t saved_program_counter_nxt;
	crs_regset_pkg::crs_word_t saved_status_word_r;
	crs_regset_pkg::crs_word_t saved_status_word_nxt;
	crs_regset_pkg::crs_word_t fast_irq_vector_r;
	crs_regset_pkg::crs_word_t fast_irq_vector_nxt;
	crs_regset_pkg::crs_word_t interrupt_table_base_r;
	crs_regset_pkg::crs_word_t interrupt_table_base_nxt;
	crs_regset_pkg::crs_word_t exception_table_base_r;
	crs_regset_pkg::crs_word_t exception_table_base_nxt;
	crs_regset_pkg::crs_flow_t flow;

	function automatic logic [XLEN-1:0] vec_addr(input logic [XLEN-1:0] base,
	                                             input logic [VEC_W-1:0] num);
		logic [XLEN-1:0] ofs;
		ofs      = {{(XLEN-VEC_W){1'b0}}, num} << `CRS_VEC_SHIFT;
		vec_addr = base + ofs;
	endfunction

	function automatic logic is_cr(input logic [`CRS_CR_IDX_W-1:0] idx,
	                               input logic [`CRS_CR_IDX_W-1:0] want);
		is_cr = cr_wr_i && (idx == want);
	endfunction

	// Register-zero traffic follows the live select bit.
	assign gpr.rd_a_idx       = rd_a_idx_i;
	assign gpr.rd_b_idx       = rd_b_idx_i;
	assign gpr.wr_en          = gpr_wr_i;
	assign gpr.wr_idx         = gpr_wr_idx_i;
	assign gpr.wr_data        = gpr_wr_data_i;
	assign gpr.stack_sel_user = processor_status_word_r[`CRS_PSW_U_BIT];
	assign gpr.sp_cr_we       = cr_wr_i && (cr_idx_i == `CRS_CR_ISP || cr_idx_i == `CRS_CR_USP);
	assign gpr.sp_cr_user     = (cr_idx_i == `CRS_CR_USP);
	assign gpr.sp_cr_data     = cr_wr_data_i;

	crs_gpr_bank #(
		.XLEN (XLEN)
	) u_bank (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_sync_r),
		.gpr     (gpr.bank)
	);

	always_comb begin
		if (fast_irq_ack_i) begin
			flow = crs_regset_pkg::CRS_FLOW_FAST_ENTRY;
		end else if (fast_irq_ret_i) begin
			flow = crs_regset_pkg::CRS_FLOW_FAST_RETURN;
		end else begin
			flow = crs_regset_pkg::CRS_FLOW_RUN;
		end
	end

	always_comb begin
		program_counter_nxt       = program_counter_r;
		processor_status_word_nxt = processor_status_word_r;
		saved_program_counter_nxt = saved_program_counter_r;
		saved_status_word_nxt     = saved_status_word_r;
		fast_irq_vector_nxt       = fast_irq_vector_r;
		interrupt_table_base_nxt  = interrupt_table_base_r;
		exception_table_base_nxt  = exception_table_base_r;
		if (is_cr(cr_idx_i, `CRS_CR_INTERRUPT_TABLE_BASE)) begin
			interrupt_table_base_nxt = cr_wr_data_i;
		end
		if (is_cr(cr_idx_i, `CRS_CR_EXCEPTION_TABLE_BASE)) begin
			exception_table_base_nxt = cr_wr_data_i;
		end
		if (is_cr(cr_idx_i, `CRS_CR_FAST_IRQ_VECTOR)) begin
			fast_irq_vector_nxt = cr_wr_data_i;
		end
		if (is_cr(cr_idx_i, `CRS_CR_BPC)) begin
			saved_program_counter_nxt = cr_wr_data_i;
		end
		if (is_cr(cr_idx_i, `CRS_CR_SAVED_STATUS_WORD)) begin
			saved_status_word_nxt = cr_wr_data_i;
		end
		if (psw_load_i) begin
			processor_status_word_nxt = psw_next_i;
		end
		if (is_cr(cr_idx_i, `CRS_CR_PSW)) begin
			processor_status_word_nxt = cr_wr_data_i;
		end
		if (pc_load_i) begin
			program_counter_nxt = pc_next_i;
		end
		case (flow)
			crs_regset_pkg::CRS_FLOW_FAST_ENTRY: begin
				// Saving into registers avoids the stack pushes of an ordinary interrupt.
				saved_program_counter_nxt = program_counter_r;
				saved_status_word_nxt     = processor_status_word_r;
				program_counter_nxt       = fast_irq_vector_r;
				processor_status_word_nxt = processor_status_word_r;
				processor_status_word_nxt[`CRS_PSW_U_BIT] = 1'b0;
			end
			crs_regset_pkg::CRS_FLOW_FAST_RETURN: begin
				program_counter_nxt       = saved_program_counter_r;
				processor_status_word_nxt = saved_status_word_r;
			end
			crs_regset_pkg::CRS_FLOW_RUN: begin
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			program_counter_r       <= RESET_PC;
			processor_status_word_r <= `CRS_RST_WORD;
			saved_program_counter_r <= `CRS_RST_WORD;
			saved_status_word_r     <= `CRS_RST_WORD;
			fast_irq_vector_r       <= `CRS_RST_WORD;
			interrupt_table_base_r  <= `CRS_RST_WORD;
			exception_table_base_r  <= `CRS_RST_WORD;
		end else begin
			program_counter_r       <= program_counter_nxt;
			processor_status_word_r <= processor_status_word_nxt;
			saved_program_counter_r <= saved_program_counter_nxt;
			saved_status_word_r     <= saved_status_word_nxt;
			fast_irq_vector_r       <= fast_irq_vector_nxt;
			interrupt_table_base_r  <= interrupt_table_base_nxt;
			exception_table_base_r  <= exception_table_base_nxt;
		end
	end

	// Registered read and address outputs.
	logic [XLEN-1:0] rd_a_nxt;
	logic [XLEN-1:0] rd_b_nxt;
	logic [XLEN-1:0] cr_rd_nxt;
	logic [XLEN-1:0] exc_vec_nxt;
	logic [XLEN-1:0] irq_vec_nxt;
	logic [XLEN-1:0] sp_nxt;

	always_comb begin
		rd_a_nxt    = gpr.rd_a_data;
		rd_b_nxt    = gpr.rd_b_data;
		exc_vec_nxt = vec_addr(exception_table_base_r, exc_vec_num_i);
		irq_vec_nxt = vec_addr(interrupt_table_base_r, irq_vec_num_i);
		sp_nxt      = processor_status_word_r[`CRS_PSW_U_BIT] ? gpr.usp_val : gpr.isp_val;
		case (cr_idx_i)
			`CRS_CR_ISP:   cr_rd_nxt = gpr.isp_val;
			`CRS_CR_USP:   cr_rd_nxt = gpr.usp_val;
			`CRS_CR_INTERRUPT_TABLE_BASE:  cr_rd_nxt = interrupt_table_base_r;
			`CRS_CR_PC:    cr_rd_nxt = program_counter_r;
			`CRS_CR_PSW:   cr_rd_nxt = processor_status_word_r;
			`CRS_CR_BPC:   cr_rd_nxt = saved_program_counter_r;
			`CRS_CR_SAVED_STATUS_WORD:  cr_rd_nxt = saved_status_word_r;
			`CRS_CR_FAST_IRQ_VECTOR: cr_rd_nxt = fast_irq_vector_r;
			`CRS_CR_EXCEPTION_TABLE_BASE:  cr_rd_nxt = exception_table_base_r;
			default:       cr_rd_nxt = `CRS_RST_WORD;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rd_a_data_o     <= `CRS_RST_WORD;
			rd_b_data_o     <= `CRS_RST_WORD;
			cr_rd_data_o    <= `CRS_RST_WORD;
			exc_vec_addr_o  <= `CRS_RST_WORD;
			irq_vec_addr_o  <= `CRS_RST_WORD;
			stack_pointer_o <= `CRS_RST_WORD;
		end else begin
			rd_a_data_o     <= rd_a_nxt;
			rd_b_data_o     <= rd_b_nxt;
			cr_rd_data_o    <= cr_rd_nxt;
			exc_vec_addr_o  <= exc_vec_nxt;
			irq_vec_addr_o  <= irq_vec_nxt;
			stack_pointer_o <= sp_nxt;
		end
	end

	assign program_counter_o       = program_counter_r;
	assign processor_status_word_o = processor_status_word_r;
	assign stack_sel_user_o        = processor_status_word_r[`CRS_PSW_U_BIT];
endmodule // crs_regset
`default_nettype wire

// ---- include/crs_regset_defs.svh ----
`ifndef CRS_REGSET_DEFS_SVH
`define CRS_REGSET_DEFS_SVH

`define CRS_XLEN         32
`define CRS_GPR_COUNT    16
`define CRS_GPR_IDX_W    4
`define CRS_PSW_U_BIT    17
`define CRS_VEC_SHIFT    2

`define CRS_CR_IDX_W     4
`define CRS_CR_ISP       4'h0
`define CRS_CR_USP       4'h1
`define CRS_CR_INTERRUPT_TABLE_BASE      4'h2
`define CRS_CR_PC        4'h3
`define CRS_CR_PSW       4'h4
`define CRS_CR_BPC       4'h5
`define CRS_CR_SAVED_STATUS_WORD      4'h6
`define CRS_CR_FAST_IRQ_VECTOR     4'h7
`define CRS_CR_EXCEPTION_TABLE_BASE      4'h8

`define CRS_RST_WORD     32'h0000_0000

`endif

// ---- include/crs_regset_pkg.sv ----
package crs_regset_pkg;
	typedef logic [31:0] crs_word_t;
	typedef logic [3:0]  crs_gpr_idx_t;
	typedef enum logic [1:0] {
		CRS_FLOW_RUN,
		CRS_FLOW_FAST_ENTRY,
		CRS_FLOW_FAST_RETURN
	} crs_flow_t;
endpackage

// ---- include/crs_gpr_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface crs_gpr_if;
	crs_regset_pkg::crs_gpr_idx_t rd_a_idx;
	crs_regset_pkg::crs_gpr_idx_t rd_b_idx;
	crs_regset_pkg::crs_word_t    rd_a_data;
	crs_regset_pkg::crs_word_t    rd_b_data;
	logic                         wr_en;
	crs_regset_pkg::crs_gpr_idx_t wr_idx;
	crs_regset_pkg::crs_word_t    wr_data;
	logic                         stack_sel_user;
	logic                         sp_cr_we;
	logic                         sp_cr_user;
	crs_regset_pkg::crs_word_t    sp_cr_data;
	crs_regset_pkg::crs_word_t    isp_val;
	crs_regset_pkg::crs_word_t    usp_val;

	modport core (
		output rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data,
		output stack_sel_user, sp_cr_we, sp_cr_user, sp_cr_data,
		input  rd_a_data, rd_b_data, isp_val, usp_val
	);
	modport bank (
		input  rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data,
		input  stack_sel_user, sp_cr_we, sp_cr_user, sp_cr_data,
		output rd_a_data, rd_b_data, isp_val, usp_val
	);
endinterface
`default_nettype wire

// ---- src/crs_gpr_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "crs_regset_defs.svh"
module crs_gpr_bank #(
	parameter int XLEN = `CRS_XLEN
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Core side
	crs_gpr_if.bank   gpr
);
	logic [XLEN-1:0] gpr_r   [1:`CRS_GPR_COUNT-1];
	logic [XLEN-1:0] gpr_nxt [1:`CRS_GPR_COUNT-1];
	logic [XLEN-1:0] isp_r;
	logic [XLEN-1:0] isp_nxt;
	logic [XLEN-1:0] usp_r;
	logic [XLEN-1:0] usp_nxt;

	function automatic logic [XLEN-1:0] read_port(input logic [3:0] idx);
		if (idx == 4'h0) begin
			read_port = gpr.stack_sel_user ? usp_r : isp_r;
		end else begin
			read_port = gpr_r[idx];
		end
	endfunction

	// A process, because a plain assignment would only wake on the index and miss register updates.
	always_comb begin
		gpr.rd_a_data = read_port(gpr.rd_a_idx);
		gpr.rd_b_data = read_port(gpr.rd_b_idx);
	end
	assign gpr.isp_val   = isp_r;
	assign gpr.usp_val   = usp_r;

	always_comb begin
		gpr_nxt = gpr_r;
		isp_nxt = isp_r;
		usp_nxt = usp_r;
		// A control-register move lands first so an instruction write to register zero wins.
		if (gpr.sp_cr_we) begin
			if (gpr.sp_cr_user) begin
				usp_nxt = gpr.sp_cr_data;
			end else begin
				isp_nxt = gpr.sp_cr_data;
			end
		end
		if (gpr.wr_en) begin
			if (gpr.wr_idx == 4'h0) begin
				if (gpr.stack_sel_user) begin
					usp_nxt = gpr.wr_data;
				end else begin
					isp_nxt = gpr.wr_data;
				end
			end else begin
				gpr_nxt[gpr.wr_idx] = gpr.wr_data;
			end
		end
	end

	generate
		for (genvar i = 1; i < `CRS_GPR_COUNT; i++) begin : g_gpr
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					gpr_r[i] <= `CRS_RST_WORD;
				end else begin
					gpr_r[i] <= gpr_nxt[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			isp_r <= `CRS_RST_WORD;
			usp_r <= `CRS_RST_WORD;
		end else begin
			isp_r <= isp_nxt;
			usp_r <= usp_nxt;
		end
	end
endmodule // crs_gpr_bank
`default_nettype wire

// ---- verif/crs_regset_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module crs_regset_assertions (
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	// Observed ports
	input wire logic [3:0]  rd_a_idx_i,
	input wire logic [3:0]  gpr_wr_idx_i,
	input wire logic [3:0]  cr_idx_i,
	input wire logic [7:0]  exc_vec_num_i,
	input wire logic [7:0]  irq_vec_num_i,
	input wire logic        gpr_wr_i,
	input wire logic        cr_wr_i,
	input wire logic        pc_load_i,
	input wire logic        psw_load_i,
	input wire logic        fast_irq_ack_i,
	input wire logic        fast_irq_ret_i,
	input wire logic        stack_sel_user_o,
	input wire logic [31:0] gpr_wr_data_i,
	input wire logic [31:0] pc_next_i,
	input wire logic [31:0] psw_next_i,
	input wire logic [31:0] rd_a_data_o,
	input wire logic [31:0] cr_rd_data_o,
	input wire logic [31:0] exc_vec_addr_o,
	input wire logic [31:0] irq_vec_addr_o,
	input wire logic [31:0] program_counter_o,
	input wire logic [31:0] processor_status_word_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_gpr_readback: assert property ((gpr_wr_i && gpr_wr_idx_i != 4'h0) ##1
		(rd_a_idx_i == $past(gpr_wr_idx_i)) |=> rd_a_data_o == $past(gpr_wr_data_i, 2))
		else $error("register read-back wrong");
	// Both reads reflect state before the same edge, so a write there cannot skew them.
	a_sp_select: assert property ((rd_a_idx_i == 4'h0 && cr_idx_i == {3'h0, stack_sel_user_o})
		|=> rd_a_data_o == cr_rd_data_o)
		else $error("register zero is not the selected stack pointer");
	a_sel_bit: assert property ((gpr_wr_i && gpr_wr_idx_i == 4'h0 && !cr_wr_i) ##1
		(cr_idx_i == {3'h0, $past(stack_sel_user_o)}) |=> cr_rd_data_o == $past(gpr_wr_data_i, 2))
		else $error("register zero write missed the selected stack pointer");
	a_pc_load: assert property ((pc_load_i && !fast_irq_ack_i && !fast_irq_ret_i)
		|=> program_counter_o == $past(pc_next_i))
		else $error("program counter load lost");
	a_psw_load: assert property ((psw_load_i && !fast_irq_ack_i && !fast_irq_ret_i &&
		!(cr_wr_i && cr_idx_i == 4'h4)) |=> processor_status_word_o == $past(psw_next_i))
		else $error("status word load lost");
	a_irq_vec: assert property (cr_idx_i == 4'h2 |=>
		irq_vec_addr_o == cr_rd_data_o + (32'($past(irq_vec_num_i)) << 2))
		else $error("interrupt vector address wrong");
	a_exc_vec: assert property (cr_idx_i == 4'h8 |=>
		exc_vec_addr_o == cr_rd_data_o + (32'($past(exc_vec_num_i)) << 2))
		else $error("exception vector address wrong");
	a_fast_vector: assert property ((cr_idx_i == 4'h7 && !cr_wr_i) ##1 fast_irq_ack_i
		|=> program_counter_o == $past(cr_rd_data_o))
		else $error("fast entry did not branch to fast vector");
	a_fast_return: assert property (fast_irq_ack_i ##1 (fast_irq_ret_i && !fast_irq_ack_i)
		|=> program_counter_o == $past(program_counter_o, 2) &&
		processor_status_word_o == $past(processor_status_word_o, 2))
		else $error("fast return did not restore saved state");
	a_fast_sel: assert property (fast_irq_ack_i |=> !stack_sel_user_o)
		else $error("fast entry left user stack selected");
endmodule // crs_regset_assertions
bind crs_regset crs_regset_assertions u_chk (.*);
`default_nettype wire

// ---- verif/crs_regset_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module crs_regset_tb;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        gpr_wr_i, cr_wr_i, pc_load_i, psw_load_i;
	logic        fast_irq_ack_i, fast_irq_ret_i, stack_sel_user_o;
	logic [3:0]  rd_a_idx_i, rd_b_idx_i, gpr_wr_idx_i, cr_idx_i;
	logic [7:0]  exc_vec_num_i, irq_vec_num_i;
	logic [31:0] gpr_wr_data_i, cr_wr_data_i, pc_next_i, psw_next_i, cr_rd_data_o;
	logic [31:0] rd_a_data_o, rd_b_data_o, exc_vec_addr_o, irq_vec_addr_o;
	logic [31:0] program_counter_o, processor_status_word_o, stack_pointer_o;
	logic [31:0] cr_exp;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc_cnt = 0;
	logic [35:0] rows [5] = '{{4'h1, 32'h0000_0001}, {4'h7, 32'hA5A5_5A5A},
		{4'hE, 32'hFFFF_FFFF}, {4'hF, 32'h8000_0000}, {4'h2, 32'h1234_5678}};

	crs_regset uut (.*);

	always #20 ref_clk_i = ~ref_clk_i;

	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// The run is about 80 cycles, so this only fires on a hang.
	always @(posedge ref_clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 2000) begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic tick(input int n = 1);
		repeat (n) @(negedge ref_clk_i);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic gpr_wr(input logic [3:0] i, input logic [31:0] d);
		gpr_wr_idx_i = i;
		gpr_wr_data_i = d;
		gpr_wr_i = 1'b1;
		tick();
		gpr_wr_i = 1'b0;
	endtask

	task automatic cr_rd(input logic [3:0] i, input logic [31:0] e);
		cr_idx_i = i;
		tick();
		chk(cr_rd_data_o, e);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask

	initial begin
		{gpr_wr_i, cr_wr_i, pc_load_i, psw_load_i, fast_irq_ack_i, fast_irq_ret_i} = 6'h00;
		{rd_a_idx_i, rd_b_idx_i, gpr_wr_idx_i, cr_idx_i, exc_vec_num_i, irq_vec_num_i} = 32'h0;
		{gpr_wr_data_i, cr_wr_data_i, pc_next_i, psw_next_i} = 128'h0;
		tick(10);
		rst_n_i = 1'b1;
		tick(3);
		chk(program_counter_o, 32'h0);
		chk(processor_status_word_o, 32'h0);
		$display("test reset done");
		foreach (rows[k]) begin
			gpr_wr(rows[k][35:32], rows[k][31:0]);
			rd_a_idx_i = rows[k][35:32];
			rd_b_idx_i = rows[k][35:32];
			tick();
			chk(rd_a_data_o, rows[k][31:0]);
			chk(rd_b_data_o, rows[k][31:0]);
		end
		$display("test gpr rows done");
		gpr_wr(4'h0, 32'h0000_1000);
		cr_rd(4'h0, 32'h0000_1000);
		cr_rd(4'h1, 32'h0000_0000);
		psw_next_i = 32'h0002_0000;
		pulse(psw_load_i);
		chk({31'h0, stack_sel_user_o}, 32'h1);
		chk(processor_status_word_o, 32'h0002_0000);
		gpr_wr(4'h0, 32'h0000_2000);
		rd_a_idx_i = 4'h0;
		cr_rd(4'h1, 32'h0000_2000);
		chk(rd_a_data_o, 32'h0000_2000);
		cr_rd(4'h0, 32'h0000_1000);
		chk(stack_pointer_o, 32'h0000_2000);
		$display("test stack select done");
		for (int i = 0; i < 16; i++) begin
			cr_idx_i = 4'(i);
			cr_wr_data_i = 32'hC0DE_0000 | 32'(i);
			pulse(cr_wr_i);
		end
		// The program counter index ignores writes and reads the live counter, still zero.
		for (int i = 0; i < 16; i++) begin
			cr_exp = (i == 3 || i > 8) ? 32'h0 : (32'hC0DE_0000 | 32'(i));
			cr_rd(4'(i), cr_exp);
		end
		cr_idx_i = 4'h2;
		exc_vec_num_i = 8'h03;
		irq_vec_num_i = 8'hFF;
		tick();
		chk(irq_vec_addr_o, 32'hC0DE_03FE);
		chk(exc_vec_addr_o, 32'hC0DE_0014);
		pc_next_i = 32'h0000_0400;
		pulse(pc_load_i);
		cr_rd(4'h3, 32'h0000_0400);
		$display("test control regs done");
		cr_rd(4'h7, 32'hC0DE_0007);
		pulse(fast_irq_ack_i);
		chk(program_counter_o, 32'hC0DE_0007);
		chk(processor_status_word_o, 32'hC0DC_0004);
		cr_rd(4'h5, 32'h0000_0400);
		cr_rd(4'h6, 32'hC0DE_0004);
		pulse(fast_irq_ret_i);
		chk(program_counter_o, 32'h0000_0400);
		chk(processor_status_word_o, 32'hC0DE_0004);
		fast_irq_ack_i = 1'b1;
		tick();
		fast_irq_ack_i = 1'b0;
		pulse(fast_irq_ret_i);
		chk(program_counter_o, 32'h0000_0400);
		chk({31'h0, stack_sel_user_o}, 32'h1);
		$display("test fast interrupt done");
		{exc_vec_num_i, irq_vec_num_i, cr_idx_i, rd_a_idx_i} = 24'h0;
		rst_n_i = 1'b0;
		tick();
		chk(program_counter_o, 32'h0);
		rst_n_i = 1'b1;
		tick(3);
		cr_rd(4'h7, 32'h0);
		$display("test second reset done");
		// An instruction write to register zero must beat a same-cycle move to that pointer.
		cr_idx_i = 4'h0;
		gpr_wr_idx_i = 4'h0;
		gpr_wr_data_i = 32'h0000_3000;
		cr_wr_data_i = 32'h0000_4000;
		psw_next_i = 32'h0000_0001;
		{gpr_wr_i, cr_wr_i, psw_load_i} = 3'h7;
		tick();
		{gpr_wr_i, cr_wr_i, psw_load_i} = 3'h0;
		cr_rd(4'h0, 32'h0000_3000);
		chk(processor_status_word_o, 32'h0000_0001);
		$display("test priority done");
		end_sim();
	end
endmodule // crs_regset_tb
`default_nettype wire
